// ### verilog/ovsf_pkg.sv
/*
  Constants for the output slew, divider ratio and output floor command words.
  Assumes a management bus with 8-bit command codes and 16-bit little-endian data words.
*/
`default_nettype none

package ovsf_pkg;

  // Command codes of the three words
  localparam logic [7:0]  CMD_SLEW          = 8'h27;
  localparam logic [7:0]  CMD_RATIO         = 8'h29;
  localparam logic [7:0]  CMD_FLOOR         = 8'h2b;

  // Fixed exponents, read only
  localparam logic [4:0]  SLEW_EXP          = 5'h1a;   // -6
  localparam logic [4:0]  RATIO_EXP         = 5'h1e;   // -2

  // Slew mantissa, low seven bits writable, reset 60 (0.9375 mV/us)
  localparam logic [6:0]  SLEW_MANT_RESET   = 7'h3c;
  localparam logic [3:0]  SLEW_PAD          = 4'h0;

  // Upper limits of buckets 0..6; above the last is bucket 7
  localparam logic [6:0]  SLEW_BOUND [0:6]  = '{7'h05, 7'h07, 7'h0c, 7'h11, 7'h19, 7'h2f, 7'h4f};
  localparam int          SLEW_BUCKETS      = 7;

  // Divider ratio mantissas, low three bits writable
  localparam logic [2:0]  RATIO_ONE         = 3'h4;
  localparam logic [2:0]  RATIO_HALF        = 3'h2;
  localparam logic [7:0]  RATIO_PAD         = 8'h00;

  // Floor mantissa, low twelve bits writable, per-ratio default and range
  localparam logic [11:0] FLOOR_MIN_ONE     = 12'h0b3;  // 179
  localparam logic [11:0] FLOOR_MAX_ONE     = 12'h300;  // 768
  localparam logic [11:0] FLOOR_MIN_HALF    = 12'h166;  // 358
  localparam logic [11:0] FLOOR_MAX_HALF    = 12'h600;  // 1536
  localparam logic [3:0]  FLOOR_PAD         = 4'h0;

  // Bit slot counts within one bus byte
  localparam logic [3:0]  BIT_FIRST         = 4'h0;
  localparam logic [3:0]  BIT_TOP           = 4'h7;
  localparam logic [3:0]  ACK_SLOT          = 4'h8;
  localparam logic [3:0]  POST_ACK          = 4'h9;

endpackage : ovsf_pkg

`default_nettype wire

// ### verilog/ovsf_link_shift.sv
/*
  Receive shifter clocked by the bus clock pin itself.
  Assumes the system side reads the byte only while the bus clock is high after the
  eighth rising edge, when this register cannot change.
*/
`timescale 1ns/100ps
`default_nettype none

module ovsf_link_shift (
  input  wire logic       bus_clk,   // Bus clock pin, clock of the link domain
  input  wire logic       reset,     // Asynchronous reset, active high
  input  wire logic       sda_in,    // Data pin level
  output logic      [7:0] rx_byte    // Last eight bits, most significant first
);

  // Data is valid on the rising bus clock edge
  always_ff @(posedge bus_clk or posedge reset) begin
    if (reset) begin
      rx_byte <= 8'h00;
    end else begin
      rx_byte <= {rx_byte[6:0], sda_in};
    end
  end

endmodule : ovsf_link_shift

`default_nettype wire

// ### verilog/ovsf_regs.sv
/*
  Management-bus slave holding the output slew, divider ratio and output floor words,
  with floor clamping of the reference and the related status flags.
  Assumes open-drain bus pins resolved outside, no clock stretching, and a bus clock
  far slower than clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none

module ovsf_regs #(
  parameter logic [6:0] DEVICE_ADDR = 7'h24  // Bus address, value is arbitrary
) (
  input  wire logic        clk_sys,                        // System clock, 20 MHz
  input  wire logic        reset,                          // Asynchronous reset, active high
  input  wire logic        bus_clk,                        // Bus clock pin as link clock
  input  wire logic        scl_in,                         // Bus clock pin level
  input  wire logic        sda_in,                         // Bus data pin level
  output logic             sda_out,                        // Bus data drive value
  output logic             sda_oe,                         // Bus data driven low when high
  output logic             alert_out,                      // Alert drive value
  output logic             alert_oe,                       // Alert pulled low when high
  input  wire logic        loop_follower,                  // Device is a loop follower
  input  wire logic        output_on,                      // Output is enabled
  input  wire logic        soft_ramp_active,               // Soft start or stop ramp running
  input  wire logic        status_clear,                   // Clear all flags, pulse
  input  wire logic        store_defaults,                 // Store-all-defaults, pulse
  input  wire logic [15:0] effective_output_setting,       // Requested output code
  input  wire logic [15:0] upper_limit,                    // Ceiling output code
  output logic      [15:0] reference_code,                 // Internal reference code
  output logic      [2:0]  slew_select,                    // Fixed slew rate index
  output logic             slew_apply,                     // Slew setting in force
  output logic      [2:0]  nv_divider_ratio,               // Stored ratio mantissa
  output logic             comm_flag,                      // Communication summary flag
  output logic             invalid_data_flag,              // Invalid data written
  output logic             invalid_command_fault,          // Command not accessible
  output logic             misc_warning_flag,              // Other-warning summary
  output logic             output_voltage_warning_summary, // Output warning summary
  output logic             bound_warning_flag              // Output bound warning
);

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_CMD, S_DATA_LO, S_DATA_HI, S_TX_LO, S_TX_HI, S_IGNORE
  } ovsf_state_type;

  ovsf_state_type state;
  logic [2:0]  scl_sync;
  logic [2:0]  sda_sync;
  logic        scl_s;
  logic        sda_s;
  logic        scl_prev;
  logic        sda_prev;
  logic [3:0]  bit_cnt;
  logic        ack_pending;
  logic [7:0]  cmd_byte;
  logic [7:0]  data_lo;
  logic [7:0]  tx_byte;
  logic [7:0]  link_byte;
  logic [6:0]  slew_mant;
  logic [2:0]  ratio_mant;
  logic [11:0] floor_mant;
  logic [46:0] last_snap;
  logic [46:0] next_snap;
  logic [15:0] rd_word;
  logic [15:0] rx_word;
  logic [15:0] floor_code;
  logic [15:0] target;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_seen;
  logic        stop_seen;
  logic        byte_done;
  logic        ninth_rise;
  logic        tx_mode;
  logic        wr_hi;
  logic        wr_bad;
  logic        follower_hit;
  logic        clamp_now;
  logic        clamp_event;

  // Is the command one of the three words handled here
  function automatic logic is_ours(input logic [7:0] code);
    return (code == ovsf_pkg::CMD_SLEW) || (code == ovsf_pkg::CMD_RATIO) ||
           (code == ovsf_pkg::CMD_FLOOR);
  endfunction : is_ours

  // Floor mantissa legal for the given ratio
  function automatic logic floor_legal(input logic [11:0] m, input logic [2:0] r);
    if (r == ovsf_pkg::RATIO_HALF) begin
      return (m >= ovsf_pkg::FLOOR_MIN_HALF) && (m <= ovsf_pkg::FLOOR_MAX_HALF);
    end
    return (m >= ovsf_pkg::FLOOR_MIN_ONE) && (m <= ovsf_pkg::FLOOR_MAX_ONE);
  endfunction : floor_legal

  // Output code times the divider ratio
  function automatic logic [15:0] scale(input logic [15:0] code, input logic [2:0] r);
    return (r == ovsf_pkg::RATIO_HALF) ? {1'b0, code[15:1]} : code;
  endfunction : scale

  // Slew bucket from the mantissa
  function automatic logic [2:0] slew_bucket(input logic [6:0] m);
    logic [2:0] idx;
    idx = 3'(ovsf_pkg::SLEW_BUCKETS);
    for (int i = ovsf_pkg::SLEW_BUCKETS - 1; i >= 0; i--) begin
      if (m <= ovsf_pkg::SLEW_BOUND[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : slew_bucket

  // Pin synchronisers; a level counts once the second and third stages agree
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_s    <= 1'b1;
      sda_s    <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
      if (scl_sync[1] == scl_sync[2]) begin
        scl_s <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_s <= sda_sync[2];
      end
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  // Receive byte, stable while the clock is low after the eighth bit
  ovsf_link_shift u_shift (
    .bus_clk (bus_clk),
    .reset   (reset),
    .sda_in  (sda_in),
    .rx_byte (link_byte)
  );

  // Bus events and write decode
  assign scl_rise     = scl_s & ~scl_prev;
  assign scl_fall     = ~scl_s & scl_prev;
  assign start_seen   = scl_s & scl_prev & sda_prev & ~sda_s;
  assign stop_seen    = scl_s & scl_prev & ~sda_prev & sda_s;
  assign byte_done    = scl_rise && (bit_cnt == ovsf_pkg::BIT_TOP);
  assign ninth_rise   = scl_rise && (bit_cnt == ovsf_pkg::ACK_SLOT);
  assign tx_mode      = (state == S_TX_LO) || (state == S_TX_HI);
  assign rx_word      = {link_byte, data_lo};
  assign wr_hi        = byte_done && (state == S_DATA_HI) && !loop_follower;
  assign follower_hit = byte_done && (state == S_CMD) && is_ours(link_byte) &&
                        loop_follower;

  // Illegal ratio or out-of-range floor; only writable bits are judged
  always_comb begin
    wr_bad = 1'b0;
    if (wr_hi && (cmd_byte == ovsf_pkg::CMD_RATIO)) begin
      wr_bad = (rx_word[2:0] != ovsf_pkg::RATIO_ONE) &&
               (rx_word[2:0] != ovsf_pkg::RATIO_HALF);
    end else if (wr_hi && (cmd_byte == ovsf_pkg::CMD_FLOOR)) begin
      wr_bad = !floor_legal(rx_word[11:0], ratio_mant);
    end
  end

  // Read data with fixed fields in place
  always_comb begin
    rd_word = 16'h0000;
    if (cmd_byte == ovsf_pkg::CMD_SLEW) begin
      rd_word = {ovsf_pkg::SLEW_EXP, ovsf_pkg::SLEW_PAD, slew_mant};
    end else if (cmd_byte == ovsf_pkg::CMD_RATIO) begin
      rd_word = {ovsf_pkg::RATIO_EXP, ovsf_pkg::RATIO_PAD, ratio_mant};
    end else if (cmd_byte == ovsf_pkg::CMD_FLOOR) begin
      rd_word = {ovsf_pkg::FLOOR_PAD, floor_mant};
    end
  end

  // Transaction sequencer
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state       <= S_IDLE;
      bit_cnt     <= ovsf_pkg::BIT_FIRST;
      ack_pending <= 1'b0;
      cmd_byte    <= 8'h00;
      data_lo     <= 8'h00;
      tx_byte     <= 8'h00;
    end else if (start_seen) begin
      state       <= S_ADDR;
      bit_cnt     <= ovsf_pkg::BIT_FIRST;
      ack_pending <= 1'b0;
    end else if (stop_seen) begin
      state       <= S_IDLE;
      bit_cnt     <= ovsf_pkg::BIT_FIRST;
      ack_pending <= 1'b0;
    end else begin
      if (scl_rise && (bit_cnt != ovsf_pkg::POST_ACK)) begin
        bit_cnt <= 4'(bit_cnt + 4'h1);
      end
      if (byte_done) begin
        unique case (state)
          S_ADDR: begin
            if (link_byte[7:1] != DEVICE_ADDR) begin
              state <= S_IGNORE;
            end else if (!link_byte[0]) begin
              ack_pending <= 1'b1;
              state       <= S_CMD;
            end else if (is_ours(cmd_byte) && !loop_follower) begin
              ack_pending <= 1'b1;
              tx_byte     <= rd_word[7:0];
              state       <= S_TX_LO;
            end else begin
              state <= S_IGNORE;
            end
          end
          S_CMD: begin
            cmd_byte <= link_byte;
            if (is_ours(link_byte) && !loop_follower) begin
              ack_pending <= 1'b1;
              state       <= S_DATA_LO;
            end else begin
              state <= S_IGNORE;
            end
          end
          S_DATA_LO: begin
            data_lo     <= link_byte;
            ack_pending <= 1'b1;
            state       <= S_DATA_HI;
          end
          S_DATA_HI: begin
            ack_pending <= wr_hi && !wr_bad;
            state       <= S_IGNORE;
          end
          S_IDLE, S_TX_LO, S_TX_HI, S_IGNORE: begin
            state <= state;
          end
        endcase
      end
      // Host acknowledge of a sent byte
      if (ninth_rise && tx_mode && !ack_pending) begin
        if (!sda_s && (state == S_TX_LO)) begin
          tx_byte <= rd_word[15:8];
          state   <= S_TX_HI;
        end else begin
          state <= S_IGNORE;
        end
      end
      if (scl_fall && (bit_cnt == ovsf_pkg::POST_ACK)) begin
        bit_cnt     <= ovsf_pkg::BIT_FIRST;
        ack_pending <= 1'b0;
      end
    end
  end

  // Data pin drive, changed at clock falls while the clock is low, released at start or stop
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sda_oe <= 1'b0;
    end else if (start_seen || stop_seen) begin
      sda_oe <= 1'b0;
    end else if (scl_fall) begin
      if (bit_cnt == ovsf_pkg::ACK_SLOT) begin
        sda_oe <= ack_pending;
      end else if (bit_cnt == ovsf_pkg::POST_ACK) begin
        sda_oe <= tx_mode && !tx_byte[7];
      end else begin
        sda_oe <= tx_mode && !tx_byte[3'(ovsf_pkg::BIT_TOP - bit_cnt)];
      end
    end
  end

  assign sda_out   = 1'b0;
  assign alert_out = 1'b0;

  // Command words; ratio writes allowed in every state
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      slew_mant  <= ovsf_pkg::SLEW_MANT_RESET;
      ratio_mant <= ovsf_pkg::RATIO_ONE;
      floor_mant <= ovsf_pkg::FLOOR_MIN_ONE;
    end else if (wr_hi && !wr_bad) begin
      if (cmd_byte == ovsf_pkg::CMD_SLEW) begin
        slew_mant <= rx_word[6:0];
      end else if (cmd_byte == ovsf_pkg::CMD_RATIO) begin
        ratio_mant <= rx_word[2:0];
        if (rx_word[2:0] != ratio_mant) begin
          floor_mant <= (rx_word[2:0] == ovsf_pkg::RATIO_HALF) ?
                        ovsf_pkg::FLOOR_MIN_HALF : ovsf_pkg::FLOOR_MIN_ONE;
        end
      end else if (cmd_byte == ovsf_pkg::CMD_FLOOR) begin
        floor_mant <= rx_word[11:0];
      end
    end
  end

  // Nonvolatile image of the ratio
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      nv_divider_ratio <= ovsf_pkg::RATIO_ONE;
    end else if (store_defaults) begin
      nv_divider_ratio <= ratio_mant;
    end
  end

  // Slew rate selection, held off during soft ramps
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      slew_select <= 3'h0;
      slew_apply  <= 1'b0;
    end else begin
      slew_select <= slew_bucket(slew_mant);
      slew_apply  <= !soft_ramp_active;
    end
  end

  // Floor clamp; the ceiling wins when it sits below the floor
  assign floor_code  = {ovsf_pkg::FLOOR_PAD, floor_mant};
  assign clamp_now   = output_on && (effective_output_setting < floor_code);
  assign target      = !clamp_now ? effective_output_setting :
                       (upper_limit < floor_code) ? upper_limit : floor_code;
  assign next_snap   = {effective_output_setting, upper_limit, floor_mant, ratio_mant};
  assign clamp_event = clamp_now && (next_snap != last_snap);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reference_code <= 16'h0000;
      last_snap      <= 47'h0000_0000_0000;
    end else begin
      reference_code <= scale(target, ratio_mant);
      last_snap      <= next_snap;
    end
  end

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      comm_flag                      <= 1'b0;
      invalid_data_flag              <= 1'b0;
      invalid_command_fault          <= 1'b0;
      misc_warning_flag              <= 1'b0;
      output_voltage_warning_summary <= 1'b0;
      bound_warning_flag             <= 1'b0;
    end else begin
      comm_flag             <= wr_bad || follower_hit || (comm_flag && !status_clear);
      invalid_data_flag     <= wr_bad || (invalid_data_flag && !status_clear);
      invalid_command_fault <= follower_hit ||
                               (invalid_command_fault && !status_clear);
      misc_warning_flag     <= clamp_event || (misc_warning_flag && !status_clear);
      output_voltage_warning_summary <= clamp_event ||
                               (output_voltage_warning_summary && !status_clear);
      bound_warning_flag    <= clamp_event || (bound_warning_flag && !status_clear);
    end
  end

  // Alert follows any set flag
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      alert_oe <= 1'b0;
    end else begin
      alert_oe <= comm_flag || invalid_data_flag || invalid_command_fault ||
                  misc_warning_flag || output_voltage_warning_summary ||
                  bound_warning_flag;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence bad_ratio_write_s;
    wr_hi && (cmd_byte == ovsf_pkg::CMD_RATIO) && wr_bad;
  endsequence

  sequence follower_cmd_s;
    follower_hit;
  endsequence

  sequence clamp_hit_s;
    clamp_event;
  endsequence

  follower_fault_a: assert property (follower_cmd_s |=> invalid_command_fault ##1 alert_oe)
    else $error("follower access did not raise fault and alert");
  follower_nack_a: assert property (follower_cmd_s |=> state == S_IGNORE && !ack_pending)
    else $error("follower command byte was acknowledged");
  slew_low_a: assert property (slew_mant <= 7'h05 |=> slew_select == 3'h0)
    else $error("slowest slew bucket wrong");
  slew_high_a: assert property (slew_mant > 7'h4f |=> slew_select == 3'h7)
    else $error("fastest slew bucket wrong");
  ratio_legal_a: assert property (ratio_mant == ovsf_pkg::RATIO_ONE ||
                                  ratio_mant == ovsf_pkg::RATIO_HALF)
    else $error("illegal divider ratio held");
  ratio_keep_a: assert property (bad_ratio_write_s |=> $stable(ratio_mant) && comm_flag
                                 && invalid_data_flag ##1 alert_oe)
    else $error("bad ratio write not rejected");
  floor_clamp_a: assert property (clamp_now && upper_limit >= floor_code |=>
                                  reference_code == scale($past(floor_code), $past(ratio_mant)))
    else $error("reference not clamped to floor");
  floor_warn_a: assert property (clamp_hit_s |=> misc_warning_flag &&
                                 output_voltage_warning_summary && bound_warning_flag)
    else $error("clamp warnings missing");
  store_ratio_a: assert property (store_defaults |=> nv_divider_ratio == $past(ratio_mant))
    else $error("ratio not stored");
  fixed_exp_a: assert property (cmd_byte == ovsf_pkg::CMD_SLEW |->
                                rd_word[15:11] == ovsf_pkg::SLEW_EXP)
    else $error("slew exponent not fixed");

endmodule : ovsf_regs

`default_nettype wire

// ### bench/ovsf_host.sv
/*
  Bus host model: clocks the management bus only within frames and pulls data low.
  Assumes pull-ups on both pins, resolved by the bench.
*/
`timescale 1ns/100ps
`default_nettype none

module ovsf_host #(
  parameter logic [6:0] ADDR = 7'h24  // Target address, value is arbitrary
) (
  input  wire logic clk_sys,  // Pacing clock
  input  wire logic sda,      // Resolved data pin
  output logic      scl,      // Bus clock, high while idle
  output logic      sda_low   // High pulls data low
);
  // Idle bus
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Whole cycles; pins move at falling edges, 25 cycles keep the bus at 400 kHz
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wt
  // Data edge while the clock is high: start is (0,1), stop is (1,0)
  task automatic cond(input logic s0, input logic s1);
    sda_low = s0;
    wt(25);
    scl = 1'b1;
    wt(25);
    sda_low = s1;
    wt(25);
  endtask : cond
  // One bit slot; data settles in the low phase, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    wt(5);
    sda_low = !b;
    wt(20);
    scl = 1'b1;
    wt(13);
    r = sda;
    wt(12);
    scl = 1'b0;
  endtask : bit_io
  // Byte, most significant bit first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                      output logic n);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, n);
  endtask : xfer
  // Word write, low byte first; n holds the four acknowledge slots
  task automatic wr(input logic [7:0] c, input logic [15:0] d, output logic [3:0] n);
    logic [7:0] q;
    cond(1'b0, 1'b1);
    scl = 1'b0;
    xfer({ADDR, 1'b0}, 1'b1, q, n[0]);
    xfer(c, 1'b1, q, n[1]);
    xfer(d[7:0], 1'b1, q, n[2]);
    xfer(d[15:8], 1'b1, q, n[3]);
    wt(5);
    cond(1'b1, 1'b0);
  endtask : wr
  // Word read with repeated start; last byte refused to end it
  task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic [2:0] n);
    logic x;
    cond(1'b0, 1'b1);
    scl = 1'b0;
    xfer({ADDR, 1'b0}, 1'b1, d[7:0], n[0]);
    xfer(c, 1'b1, d[7:0], n[1]);
    cond(1'b0, 1'b1);
    scl = 1'b0;
    xfer({ADDR, 1'b1}, 1'b1, d[7:0], n[2]);
    xfer(8'hff, 1'b0, d[7:0], x);
    xfer(8'hff, 1'b1, d[15:8], x);
    wt(5);
    cond(1'b1, 1'b0);
  endtask : rd
endmodule : ovsf_host

`default_nettype wire

// ### bench/ovsf_regs_test.sv
/*
  Self-checking bench for the slew, divider ratio and floor command words.
  Assumes the bus host model and open-drain pins resolved here with pull-ups.
*/
`timescale 1ns/100ps
`default_nettype none

module ovsf_regs_test;
  localparam logic [7:0] SL = ovsf_pkg::CMD_SLEW;
  localparam logic [7:0] RA = ovsf_pkg::CMD_RATIO;
  localparam logic [7:0] FL = ovsf_pkg::CMD_FLOOR;
  localparam logic [6:0] EDGES [0:13] = '{7'h05, 7'h06, 7'h07, 7'h08, 7'h0c, 7'h0d,
    7'h11, 7'h12, 7'h19, 7'h1a, 7'h2f, 7'h30, 7'h4f, 7'h50};
  logic        clk_sys, reset, scl, sda_low, loop_follower, output_on, soft_ramp_active;
  logic        status_clear, store_defaults, sda_out, sda_oe, alert_out, alert_oe;
  logic        slew_apply, comm_flag, invalid_data_flag, invalid_command_fault;
  logic        misc_warning_flag, output_voltage_warning_summary, bound_warning_flag;
  logic [15:0] setting, upper, reference_code, rdata;
  logic [2:0]  slew_select, nv_divider_ratio, rn;
  logic [3:0]  wn;
  logic [6:0]  m;
  int          seed, num_errors, n_compared;
  wire         sda = !(sda_low || sda_oe);  // Pull-up
  wire  [6:0]  flg = {comm_flag, invalid_data_flag, invalid_command_fault, misc_warning_flag,
                      output_voltage_warning_summary, bound_warning_flag, alert_oe};

  ovsf_regs i_ovsf_regs (.clk_sys(clk_sys), .reset(reset), .bus_clk(scl), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .alert_out(alert_out),
    .alert_oe(alert_oe), .loop_follower(loop_follower), .output_on(output_on),
    .soft_ramp_active(soft_ramp_active), .status_clear(status_clear),
    .store_defaults(store_defaults), .effective_output_setting(setting),
    .upper_limit(upper), .reference_code(reference_code), .slew_select(slew_select),
    .slew_apply(slew_apply), .nv_divider_ratio(nv_divider_ratio), .comm_flag(comm_flag),
    .invalid_data_flag(invalid_data_flag), .invalid_command_fault(invalid_command_fault),
    .misc_warning_flag(misc_warning_flag), .bound_warning_flag(bound_warning_flag),
    .output_voltage_warning_summary(output_voltage_warning_summary));
  ovsf_host i_ovsf_host (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_low(sda_low));

  `define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("FAIL %s expected %h seen %h", nm, e, g); end end

  // Helpers for waits, word accesses and flag clearing
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic w(input logic [7:0] c, input logic [15:0] d);
    i_ovsf_host.wr(c, d, wn);
  endtask : w
  task automatic rdc(input logic [7:0] c, input logic [15:0] e);
    i_ovsf_host.rd(c, rdata, rn);
    `CHK("read word", e, rdata)
  endtask : rdc
  task automatic clr();
    status_clear = 1'b1;
    cyc(1);
    status_clear = 1'b0;
    cyc(3);
    `CHK("cleared", 7'h00, flg)
  endtask : clr
  // Expected rate index: count of bucket limits exceeded
  function automatic logic [2:0] bucket(input logic [6:0] v);
    bucket = 3'h0;
    for (int i = 0; i < 7; i++) bucket += 3'(v > ovsf_pkg::SLEW_BOUND[i]);
  endfunction : bucket
  // Counts, verdict and end of run
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  // System clock, 50 ns
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = !clk_sys;
  end
  // Watchdog, just under 100k cycles
  initial begin
    #4900000;
    num_errors++;
    summarize();
  end
  // Test sequence
  initial begin
    seed = 24674;
    num_errors = 0;
    n_compared = 0;
    {reset, loop_follower, output_on, soft_ramp_active, status_clear, store_defaults} = 6'h20;
    setting = 16'h0190;
    upper = 16'h0320;
    cyc(12);
    reset = 1'b0;
    cyc(8);
    `CHK("reset rates", 6'h34, {slew_select, nv_divider_ratio})
    `CHK("drive values", 2'h0, {sda_out, alert_out})
    rdc(SL, 16'hd03c);
    rdc(RA, 16'hf004);
    rdc(FL, 16'h00b3);
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      m = (i < 14) ? EDGES[i] : 7'($random(seed));
      w(SL, {9'($random(seed)), m});
      `CHK("slew", {4'h0, bucket(m)}, {wn, slew_select})
    end
    rdc(SL, {ovsf_pkg::SLEW_EXP, 4'h0, m});
    soft_ramp_active = 1'b1;
    cyc(2);
    `CHK("ramp", 1'b0, slew_apply)
    soft_ramp_active = 1'b0;
    cyc(2);
    `CHK("normal", 1'b1, slew_apply)
    $display("slew test done");
    output_on = 1'b1;
    w(RA, {13'($random(seed)), 3'h5});
    `CHK("bad ratio", 11'h461, {wn, flg})
    rdc(RA, 16'hf004);
    clr();
    w(RA, {13'($random(seed)), 3'h2});
    rdc(RA, 16'hf002);
    rdc(FL, 16'h0166);
    store_defaults = 1'b1;
    cyc(1);
    store_defaults = 1'b0;
    cyc(2);
    `CHK("stored ratio", 3'h2, nv_divider_ratio)
    $display("ratio test done");
    w(FL, 16'h0165);
    `CHK("floor 357", 11'h461, {wn, flg})
    clr();
    w(FL, 16'hf600);
    `CHK("floor 1536", 11'h00f, {wn, flg})
    `CHK("half ref", 16'h0190, reference_code)
    w(FL, 16'h0601);
    `CHK("floor 1537", 4'h8, wn)
    rdc(FL, 16'h0600);
    clr();
    $display("floor test done");
    w(RA, 16'hf004);
    w(FL, 16'h012c);
    clr();
    `CHK("no clamp", 16'h0190, reference_code)
    setting = 16'h00c8;
    cyc(4);
    `CHK("clamp", 23'h00960f, {reference_code, flg})
    upper = 16'h00fa;
    cyc(4);
    `CHK("upper wins", 16'h00fa, reference_code)
    upper = 16'h0320;
    cyc(4);
    clr();
    w(RA, 16'hf002);
    `CHK("ratio clamp", 23'h00598f, {reference_code, flg})
    $display("clamp test done");
    output_on = 1'b0;
    loop_follower = 1'b1;
    clr();
    w(SL, 16'h0005);
    `CHK("follower write", 11'h751, {wn, flg})
    i_ovsf_host.rd(FL, rdata, rn);
    `CHK("follower read", 3'h6, rn)
    loop_follower = 1'b0;
    clr();
    rdc(SL, {ovsf_pkg::SLEW_EXP, 4'h0, m});
    $display("follower test done");
    summarize();
  end
endmodule : ovsf_regs_test

`default_nettype wire
